// *** common/rfp_pkg.sv ***
// Shared constants for the transmitter control device and its host.
package rfp_pkg;
    // Configuration word field positions.
    localparam int CFG_WIDTH = 32;
    localparam int CARRIER_LSB = 0;
    localparam int CARRIER_WIDTH = 15;
    localparam int BAND_BIT = 15;
    localparam int MOD_BIT = 16;
    localparam int DEV_LSB = 17;
    localparam int DEV_WIDTH = 8;
    localparam int PWR_LSB = 25;
    localparam int PWR_WIDTH = 4;
    localparam int CLKONLY_BIT = 29;
    localparam int CLKON_BIT = 30;
    localparam int DIVSEL_BIT = 31;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    // Division ratio integer part in half units: 24 and 32.5.
    localparam logic [6:0] INT_HALVES_LOW = 7'h30;
    localparam logic [6:0] INT_HALVES_HIGH = 7'h41;
    // Legal programming ranges.
    localparam logic [14:0] CARRIER_MIN = 15'h09C4;
    localparam logic [14:0] CARRIER_MAX = 15'h55F0;
    localparam logic [7:0] DEV_MIN = 8'h01;
    // Timing.
    localparam int CLK_PERIOD_NS = 25;
    localparam int LOCK_PERIODS = 1280;
    localparam int LOCK_CYCLES = LOCK_PERIODS;
    localparam int SCK_HALF_NS = 100;
    localparam int SCK_HALF_CYCLES =
        (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] DIV4_LAST = 3'h3;
    localparam logic [2:0] DIV8_LAST = 3'h7;
    // Host register map and fields.
    localparam logic [3:0] REG_CONFIG = 4'h0;
    localparam logic [3:0] REG_CTRL = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_START = 1;
    localparam int CTRL_TXDATA = 2;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_REJECT = 2;
    localparam int STAT_CLKOUT = 3;
    typedef enum logic [1:0] {
        RFP_IDLE,
        RFP_SCK_LOW,
        RFP_SCK_HIGH
    } rfp_host_state_t;
endpackage : rfp_pkg

// *** common/rfp_link_if.sv ***
// Pins between the host microcontroller and the transmitter device.
`timescale 1ns/1ps
interface rfp_link_if;
    logic serialClk;
    logic serialTxDataIn;
    logic chipEnable;
    logic clockOut;
    modport device (
        input serialClk,
        input serialTxDataIn,
        input chipEnable,
        output clockOut
    );
    modport host (
        output serialClk,
        output serialTxDataIn,
        output chipEnable,
        input clockOut
    );
endinterface : rfp_link_if

// *** src/rfp_device.sv ***
// Transmitter device: configuration shift-in, PLL control, clock driver.
//
// Overview of operation
// - All PLL settings come from one 32-bit word.
// - Carrier from 15-bit word plus band flag.
// - Modulation flag picks ASK or divider-based FSK.
// - Deviation from 8-bit word, host writes 1-255.
// - PLL counts locked after 1280 crystal periods.
// - Band low uses integer part 24.
// - Band high uses integer part 32.5.
// - FSK high adds deviation to carrier word.
// - ASK adds half deviation, rounded down.
// - Host keeps carrier word within 2500-22000.
// - Amplifier on after lock and finished loading.
// - FSK radiates at once; ASK needs data high.
// - FSK data high selects upper frequency.
// - Four-bit field sets amplifier pulse level.
// - Enable starts oscillator; amplitude raises ready flag.
// - Clock-only clear means normal PLL operation.
// - Clock-only set powers down all but oscillator.
// - Clock output divides by 4 or 8.
// - Clock output only while its enable set.
// - Output low until ready and enable both set.
// - Activation aligned so first period is whole.
// - One pin carries serial and transmit data.
`timescale 1ns/1ps
module rfp_device (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Pins to the host.
    rfp_link_if.device link,
    // Oscillator amplitude detector.
    input wire logic oscAmplitudeOk,
    // Oscillator and PLL status.
    output logic oscReady,
    output logic pllRun,
    output logic pllLocked,
    output logic configLoaded,
    output logic [rfp_pkg::CFG_WIDTH-1:0] configWord,
    // Transmitter controls.
    output logic paEnable,
    output logic rfOn,
    output logic [rfp_pkg::PWR_WIDTH-1:0] paPulseLevel,
    output logic [6:0] divIntHalves,
    output logic [15:0] divFrac
);
    import rfp_pkg::*;

    logic sckPrev;
    logic [31:0] shiftReg;
    logic [4:0] bitCnt;
    logic [10:0] lockCnt;
    logic clkActive;
    logic clkDiv4;
    logic [2:0] divCnt;
    logic clkOutReg;
    logic sckRise;
    logic shifting;
    logic powerDown;
    logic [14:0] carrier;
    logic [7:0] deviation;
    logic bandHigh;
    logic askMode;
    logic clockOnly;
    logic clockOn;
    logic divSel;
    logic wantClk;
    logic [2:0] lastCnt;
    logic next_clkActive;
    logic next_clkDiv4;
    logic [2:0] next_divCnt;

    // Fractional numerator N; the ratio is (N + 0.5) / 16384.
    function automatic logic [15:0] frac_num(input logic [14:0] base,
                                             input logic [7:0] dev,
                                             input logic ask,
                                             input logic dataHigh);
        logic [15:0] add;
        add = 16'h0000;
        if (ask) begin
            add = {9'h000, dev[7:1]};
        end else if (dataHigh) begin
            add = {8'h00, dev};
        end
        frac_num = {1'b0, base} + add;
    endfunction : frac_num

    // Fields of the configuration word.
    assign carrier = configWord[CARRIER_LSB +: CARRIER_WIDTH];
    assign bandHigh = configWord[BAND_BIT];
    assign askMode = configWord[MOD_BIT];
    assign deviation = configWord[DEV_LSB +: DEV_WIDTH];
    assign clockOnly = configWord[CLKONLY_BIT];
    assign clockOn = configWord[CLKON_BIT];
    assign divSel = configWord[DIVSEL_BIT];
    assign powerDown = !link.chipEnable;
    assign sckRise = link.serialClk && !sckPrev;
    assign shifting = bitCnt != 5'h00;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sckPrev <= 1'b0;
        end else begin
            sckPrev <= link.serialClk;
        end
    end

    // The shared pin is read as serial data on rising serial clock edges.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || powerDown) begin
            bitCnt <= 5'h00;
            shiftReg <= 32'h0000_0000;
        end else if (sckRise) begin
            shiftReg <= {shiftReg[30:0],
                link.serialTxDataIn};
            bitCnt <= bitCnt + 5'h01;
        end
    end

    // The word takes effect only once all 32 bits are in.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            configWord <= CFG_RESET;
            configLoaded <= 1'b0;
        end else if (!powerDown && sckRise && bitCnt == 5'h1F) begin
            configWord <= {shiftReg[30:0], link.serialTxDataIn};
            configLoaded <= 1'b1;
        end
    end

    // Ready is set by the amplitude detector and held until disabled.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || powerDown) begin
            oscReady <= 1'b0;
        end else if (oscAmplitudeOk) begin
            oscReady <= 1'b1;
        end
    end

    // PLL runs only in normal mode with a loaded word.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pllRun <= 1'b0;
        end else begin
            pllRun <= oscReady && configLoaded && !clockOnly &&
                !powerDown;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst || !pllRun) begin
            lockCnt <= 11'h000;
            pllLocked <= 1'b0;
        end else if (lockCnt == 11'(LOCK_CYCLES - 1)) begin
            pllLocked <= 1'b1;
        end else begin
            lockCnt <= lockCnt + 11'h001;
        end
    end

    // Amplifier and modulation controls.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            paEnable <= 1'b0;
            rfOn <= 1'b0;
            paPulseLevel <= 4'h0;
            divIntHalves <= INT_HALVES_LOW;
            divFrac <= 16'h0000;
        end else begin
            paEnable <= pllLocked && pllRun && configLoaded &&
                !shifting;
            rfOn <= paEnable &&
                (!askMode || link.serialTxDataIn);
            paPulseLevel <= paEnable ?
                configWord[PWR_LSB +: PWR_WIDTH] : 4'h0;
            divIntHalves <= bandHigh ?
                INT_HALVES_HIGH : INT_HALVES_LOW;
            divFrac <= frac_num(carrier, deviation, askMode,
                                link.serialTxDataIn);
        end
    end

    // Clock driver: ratio and activity change only at period boundaries.
    assign wantClk = oscReady && clockOn && !powerDown;
    assign lastCnt = clkDiv4 ? DIV4_LAST : DIV8_LAST;

    always_comb begin
        next_clkActive = clkActive;
        next_clkDiv4 = clkDiv4;
        next_divCnt = divCnt + 3'h1;
        if (!clkActive) begin
            next_clkActive = wantClk;
            next_clkDiv4 = divSel;
            next_divCnt = 3'h0;
        end else if (divCnt == lastCnt) begin
            next_clkActive = wantClk;
            next_clkDiv4 = divSel;
            next_divCnt = 3'h0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            clkActive <= 1'b0;
            clkDiv4 <= 1'b0;
            divCnt <= 3'h0;
            clkOutReg <= 1'b0;
        end else begin
            clkActive <= next_clkActive;
            clkDiv4 <= next_clkDiv4;
            divCnt <= next_divCnt;
            // High for the first half of each full period.
            clkOutReg <= next_clkActive && (next_divCnt <=
                (next_clkDiv4 ? 3'h1 : 3'h3));
        end
    end

    assign link.clockOut = clkOutReg;
endmodule : rfp_device

// *** src/rfp_host.sv ***
// Host end: AHB-Lite registers driving the serial and transmit pins.
`timescale 1ns/1ps
module rfp_host (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Pins to the device.
    rfp_link_if.host link
);
    import rfp_pkg::*;

    rfp_host_state_t state;
    logic [31:0] cfgReg;
    logic [31:0] shiftReg;
    logic [4:0] bitsLeft;
    logic [2:0] halfCnt;
    logic enableReg;
    logic txDataReg;
    logic doneFlag;
    logic rejectFlag;
    logic sckReg;
    logic dataReg;
    logic wrPend;
    logic [3:0] wrAddr;
    logic addrPhase;
    logic startReq;
    logic cfgValid;
    logic sendDone;
    logic halfEnd;
    logic [14:0] cfgCarrier;
    logic [7:0] cfgDev;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addrPhase = hsel && htrans[1] && hready;
    assign startReq = wrPend && wrAddr == REG_CTRL && hwdata[CTRL_START];
    assign cfgCarrier = cfgReg[CARRIER_LSB +: CARRIER_WIDTH];
    assign cfgDev = cfgReg[DEV_LSB +: DEV_WIDTH];
    // Out-of-range words are never sent.
    assign cfgValid = cfgCarrier >= CARRIER_MIN &&
        cfgCarrier <= CARRIER_MAX && cfgDev >= DEV_MIN;
    assign halfEnd = halfCnt == 3'(SCK_HALF_CYCLES - 1);
    assign sendDone = state == RFP_SCK_HIGH && halfEnd && bitsLeft == 5'h00;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wrPend <= 1'b0;
            wrAddr <= 4'h0;
            hrdata <= 32'h0000_0000;
        end else begin
            wrPend <= addrPhase && hwrite;
            wrAddr <= haddr[3:0];
            if (addrPhase && !hwrite) begin
                unique case (haddr[3:0])
                    REG_CONFIG: hrdata <= cfgReg;
                    REG_CTRL: hrdata <= {29'h0, txDataReg, 1'b0, enableReg};
                    REG_STATUS: hrdata <= {28'h0, link.clockOut, rejectFlag,
                                           doneFlag, state != RFP_IDLE};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cfgReg <= 32'h0000_0000;
            enableReg <= 1'b0;
            txDataReg <= 1'b0;
        end else if (wrPend && wrAddr == REG_CONFIG &&
                     state == RFP_IDLE) begin
            cfgReg <= hwdata;
        end else if (wrPend && wrAddr == REG_CTRL) begin
            enableReg <= hwdata[CTRL_ENABLE];
            txDataReg <= hwdata[CTRL_TXDATA];
        end
    end

    // Sticky flags; a new event wins over a clear in the same cycle.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            doneFlag <= 1'b0;
            rejectFlag <= 1'b0;
        end else begin
            if (sendDone) begin
                doneFlag <= 1'b1;
            end else if (wrPend && wrAddr == REG_STATUS &&
                         hwdata[STAT_DONE]) begin
                doneFlag <= 1'b0;
            end
            if (startReq && (state != RFP_IDLE || !cfgValid)) begin
                rejectFlag <= 1'b1;
            end else if (wrPend && wrAddr == REG_STATUS &&
                         hwdata[STAT_REJECT]) begin
                rejectFlag <= 1'b0;
            end
        end
    end

    // Serial sender: data set while clock low, MSB first.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= RFP_IDLE;
            shiftReg <= 32'h0000_0000;
            bitsLeft <= 5'h00;
            halfCnt <= 3'h0;
            sckReg <= 1'b0;
        end else begin
            unique case (state)
                RFP_IDLE: begin
                    sckReg <= 1'b0;
                    halfCnt <= 3'h0;
                    if (startReq && cfgValid && enableReg) begin
                        shiftReg <= cfgReg;
                        bitsLeft <= 5'h1F;
                        state <= RFP_SCK_LOW;
                    end
                end
                RFP_SCK_LOW: begin
                    halfCnt <= halfEnd ? 3'h0 : halfCnt + 3'h1;
                    if (halfEnd) begin
                        sckReg <= 1'b1;
                        state <= RFP_SCK_HIGH;
                    end
                end
                RFP_SCK_HIGH: begin
                    halfCnt <= halfEnd ? 3'h0 : halfCnt + 3'h1;
                    if (halfEnd) begin
                        sckReg <= 1'b0;
                        shiftReg <= {shiftReg[30:0], 1'b0};
                        bitsLeft <= bitsLeft - 5'h01;
                        state <= (bitsLeft == 5'h00) ? RFP_IDLE : RFP_SCK_LOW;
                    end
                end
            endcase
        end
    end

    // One pin: config bits while sending, transmit data otherwise.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dataReg <= 1'b0;
        end else if (state == RFP_IDLE &&
                     !(startReq && cfgValid && enableReg)) begin
            dataReg <= txDataReg;
        end else if (state == RFP_IDLE) begin
            dataReg <= cfgReg[31];
        end else if (state == RFP_SCK_HIGH && halfEnd) begin
            dataReg <= (bitsLeft == 5'h00) ? txDataReg : shiftReg[30];
        end
    end

    assign link.serialClk = sckReg;
    assign link.serialTxDataIn = dataReg;
    assign link.chipEnable = enableReg;
endmodule : rfp_host

// *** testbench/rfp_link_sva.sv ***
// Assertions on the pins between the host and the transmitter device.
`timescale 1ns/1ps
module rfp_link_sva (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Link pins.
    input wire logic serialClk,
    input wire logic serialTxDataIn,
    input wire logic chipEnable,
    input wire logic clockOut
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    sck_high_a: assert property (
        $rose(serialClk) |-> serialClk [*4] ##1 !serialClk)
        else $error("serial clock high phase wrong");
    sck_low_a: assert property (
        $fell(serialClk) |-> !serialClk [*4])
        else $error("serial clock low phase short");
    data_hold_a: assert property (
        serialClk && $past(serialClk) |-> $stable(serialTxDataIn))
        else $error("data moved while serial clock high");
    sck_enabled_a: assert property (
        serialClk |-> chipEnable)
        else $error("serial clock while disabled");
    clk_high_min_a: assert property (
        $rose(clockOut) |=> clockOut)
        else $error("clock high pulse short");
    clk_high_max_a: assert property (
        $rose(clockOut) |-> ##[2:4] !clockOut)
        else $error("clock high pulse long");
    clk_low_min_a: assert property (
        $fell(clockOut) |=> !clockOut)
        else $error("clock low pulse short");
    clk_period_a: assert property (
        $rose(clockOut) |=> (!$rose(clockOut)) [*3])
        else $error("clock period below four");
    clk_off_a: assert property (
        !chipEnable [*8] ##1 !chipEnable [*3] |=> !clockOut)
        else $error("clock running in power-down");
    clk_start_a: assert property (
        !chipEnable [*8] ##1 !chipEnable [*4] ##1 chipEnable
        |-> !clockOut [*2])
        else $error("clock active before ready");
endmodule : rfp_link_sva

// *** testbench/rfp_tb.sv ***
// Self-checking bench joining the host and the transmitter device.
`timescale 1ns/1ps
module rfp_tb;
    import rfp_pkg::*;
    typedef struct {
        logic [31:0] word;
        logic pin;
        logic [6:0] ih;
        logic [15:0] fr;
        logic [31:0] per;
        logic pa;
        logic rf;
    } rfp_row_t;
    localparam logic [31:0] AC = {28'h0, REG_CONFIG};
    localparam logic [31:0] AT = {28'h0, REG_CTRL};
    localparam logic [31:0] AS = {28'h0, REG_STATUS};
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic ampOk = 1'b0;
    logic oscReady, pllRun, pllLocked, paEnable, rfOn, sckPrev, configLoaded;
    logic [31:0] configWord, cap, d, st, p;
    logic [3:0] paPulseLevel;
    logic [6:0] divIntHalves;
    logic [15:0] divFrac;
    logic [31:0] bad[3];
    int nRise = 0;
    int errCount = 0;
    int nCompared = 0;
    int cyc = 0;
    int n;
    int n0;
    rfp_row_t rows[5];
    rfp_row_t r;

    rfp_link_if link ();
    rfp_host rfp_host_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .link(link));
    rfp_device rfp_device_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .link(link), .oscAmplitudeOk(ampOk), .oscReady(oscReady),
        .pllRun(pllRun), .pllLocked(pllLocked), .configLoaded(configLoaded),
        .configWord(configWord), .paEnable(paEnable), .rfOn(rfOn),
        .paPulseLevel(paPulseLevel), .divIntHalves(divIntHalves),
        .divFrac(divFrac));
    rfp_link_sva rfp_link_sva_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .serialClk(link.serialClk), .serialTxDataIn(link.serialTxDataIn),
        .chipEnable(link.chipEnable), .clockOut(link.clockOut));

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Captures each bit on the shared pin at a rising serial clock.
    always @(negedge clk_sys) begin
        if (link.serialClk === 1'b1 && sckPrev === 1'b0) begin
            cap <= {cap[30:0], link.serialTxDataIn};
            nRise <= nRise + 1;
        end
        sckPrev <= link.serialClk;
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errCount++;
            printVerdict();
        end
    end

    function automatic logic [31:0] mk(input logic [14:0] car,
        input logic band, ask, input logic [7:0] dev,
        input logic [3:0] pa_pulse_level, input logic cOnly, cOn, div4);
        return {div4, cOn, cOnly, pa_pulse_level, dev, ask, band, car};
    endfunction : mk

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [31:0] a,
        input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        d = hrdata;
    endtask : bus

    task automatic waitDone();
        n = 0;
        d = 32'h0;
        while (d[STAT_DONE] !== 1'b1 && n < 600) begin
            bus(1'b0, AS, 32'h0);
            n++;
        end
        st = d;
        chk(st[STAT_DONE], 1'b1);
        bus(1'b1, AS, 32'h6);
    endtask : waitDone

    // Returns the first whole clock output period, or zero if none.
    task automatic period();
        int k;
        int t0;
        logic prv;
        p = 32'h0;
        t0 = -1;
        prv = 1'b1;
        for (k = 0; k < 24; k++) begin
            @(negedge clk_sys);
            if (link.clockOut === 1'b1 && prv === 1'b0) begin
                if (t0 >= 0 && p == 32'h0) p = k - t0;
                t0 = k;
            end
            prv = link.clockOut;
        end
        @(posedge clk_sys);
    endtask : period

    task automatic printVerdict();
        $display("compared %0d, mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : printVerdict

    initial begin
        rows[0] = '{mk(15'hE92, 0, 0, 8'h64, 4'h8, 0, 1, 0), 1, 7'h30,
            16'h0EF6, 8, 1, 1};
        rows[1] = '{mk(15'h3806, 1, 0, 8'h64, 4'hF, 0, 1, 1), 0, 7'h41,
            16'h3806, 4, 1, 1};
        rows[2] = '{mk(15'h9C4, 0, 1, 8'hFF, 4'h3, 0, 0, 0), 1, 7'h30,
            16'h0A43, 0, 1, 1};
        rows[3] = '{mk(15'h55F0, 1, 1, 8'h01, 4'h0, 0, 1, 1), 0, 7'h41,
            16'h55F0, 4, 1, 0};
        rows[4] = '{mk(15'h1000, 0, 0, 8'h10, 4'h5, 1, 1, 0), 1, 7'h30,
            16'h1010, 8, 0, 0};
        bad[0] = mk(15'h9C3, 0, 0, 8'h10, 4'h5, 0, 1, 0);
        bad[1] = mk(15'h55F1, 0, 0, 8'h10, 4'h5, 0, 1, 0);
        bad[2] = mk(15'h1000, 0, 0, 8'h00, 4'h5, 0, 1, 0);
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        bus(1'b1, AT, 32'h1);
        repeat (20) @(negedge clk_sys);
        chk(oscReady, 1'b0);
        chk(link.clockOut, 1'b0);
        @(posedge clk_sys);
        ampOk <= 1'b1;
        repeat (3) @(negedge clk_sys);
        chk(oscReady, 1'b1);
        @(posedge clk_sys);
        for (int i = 0; i < 5; i++) begin
            r = rows[i];
            n0 = nRise;
            bus(1'b1, AC, r.word);
            bus(1'b1, AT, {29'h0, r.pin, 2'h3});
            waitDone();
            chk(cap, r.word);
            chk(nRise - n0, 32'h20);
            chk(configWord, r.word);
            chk(configLoaded, 1'b1);
            n = 0;
            while (paEnable !== r.pa && n < 3000) begin
                @(negedge clk_sys);
                n++;
            end
            repeat (2) @(negedge clk_sys);
            chk(paEnable, r.pa);
            chk(rfOn, r.rf);
            chk(paPulseLevel, r.word[28:25] & {4{r.pa}});
            chk(divIntHalves, r.ih);
            chk(divFrac, r.fr);
            period();
            chk(p, r.per);
        end
        bus(1'b0, 32'h0000_000C, 32'h0);
        chk(d, 32'h0);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, AC, bad[i]);
            bus(1'b1, AT, 32'h3);
            bus(1'b0, AS, 32'h0);
            chk(d[STAT_REJECT], 1'b1);
            bus(1'b1, AS, 32'h4);
            chk(configWord, rows[4].word);
        end
        // A second start and a new word while shifting are both refused.
        bus(1'b1, AC, rows[0].word);
        bus(1'b1, AT, 32'h7);
        bus(1'b1, AC, rows[1].word);
        bus(1'b1, AT, 32'h7);
        waitDone();
        chk(st[STAT_REJECT], 1'b1);
        chk(configWord, rows[0].word);
        bus(1'b1, AT, 32'h0);
        repeat (20) @(negedge clk_sys);
        chk(pllLocked, 1'b0);
        chk(paEnable, 1'b0);
        chk(link.clockOut, 1'b0);
        @(posedge clk_sys);
        bus(1'b1, AT, 32'h1);
        n = 0;
        while (pllRun !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        n = 0;
        while (pllLocked !== 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        chk((n > 1278 && n < 1282) ? 32'h1 : 32'h0, 32'h1);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(negedge clk_sys);
        chk(configWord, 32'h0);
        chk(divIntHalves, 7'h30);
        chk(configLoaded, 1'b0);
        chk(link.clockOut, 1'b0);
        chk(paEnable, 1'b0);
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        printVerdict();
    end
endmodule : rfp_tb
